// >>> include/cpv_pkg.sv
package cpv_pkg;

    // structured request kinds delivered by the protocol layer
    typedef enum logic [2:0] {
        CPV_CMD_NONE,
        CPV_CMD_DISC_IDENT,
        CPV_CMD_DISC_SVID,
        CPV_CMD_DISC_MODES,
        CPV_CMD_ENTER_MODE,
        CPV_CMD_EXIT_MODE
    } cpv_cmd_t;

    // response kinds handed to the protocol layer for transmission
    typedef enum logic [2:0] {
        CPV_RSP_IDENT_ACK,
        CPV_RSP_SVID_ACK,
        CPV_RSP_MODES_ACK,
        CPV_RSP_ENTER_ACK,
        CPV_RSP_ENTER_NAK,
        CPV_RSP_EXIT_ACK,
        CPV_RSP_ACCEPT
    } cpv_rsp_t;

    // policy manager query kinds
    typedef enum logic [2:0] {
        CPV_ASK_IDENT,
        CPV_ASK_SVID,
        CPV_ASK_MODES,
        CPV_ASK_ENTER,
        CPV_ASK_EXIT
    } cpv_ask_t;

    localparam int CPV_OBJ_W = 32;
    localparam logic [CPV_OBJ_W-1:0] CPV_OBJ_RST = 32'h0000_0000;

    // incoming request from the protocol layer
    typedef struct packed {
        logic                 valid;
        cpv_cmd_t             cmd;
        logic [CPV_OBJ_W-1:0] obj;
    } cpv_req_t;

    // request to the policy manager
    typedef struct packed {
        logic                 valid;
        cpv_ask_t             ask;
        logic [CPV_OBJ_W-1:0] obj;
    } cpv_pm_req_t;

    // answer from the policy manager
    typedef struct packed {
        logic                 valid;
        logic                 nak;
        logic [CPV_OBJ_W-1:0] obj;
    } cpv_pm_ans_t;

    // transmit request towards the protocol layer
    typedef struct packed {
        logic                 valid;
        cpv_rsp_t             rsp;
        logic [CPV_OBJ_W-1:0] obj;
    } cpv_tx_t;

endpackage : cpv_pkg

// >>> hw/cpv_event_latch.sv
`timescale 1ns/10ps
// holds a one-cycle event until consumed; a new event wins over the consume
module cpv_event_latch
    import cpv_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic en_i,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);

    logic flag_r;
    logic flag_nxt;

    assign flag_nxt = set_i | (flag_r & ~clr_i);
    assign flag_o   = flag_r;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_r <= 1'b0;
        end else if (en_i) begin
            flag_r <= flag_nxt;
        end
    end

endmodule : cpv_event_latch

// >>> hw/cpv_reset_timer.sv
`timescale 1ns/10ps
// counts a fixed number of cycles after start_i, then pulses done_o
module cpv_reset_timer
    import cpv_pkg::*;
#(
    parameter int CYCLES = 16
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic en_i,
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE  = CW'(1);
    localparam logic [CW-1:0] ZERO = CW'(0);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    assign busy_o  = (cnt_r != ZERO);
    assign done_o  = (cnt_r == ONE) & ~start_i;
    assign cnt_nxt = start_i ? LOAD : (busy_o ? cnt_r - ONE : ZERO);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= ZERO;
        end else if (en_i) begin
            cnt_r <= cnt_nxt;
        end
    end

endmodule : cpv_reset_timer

// >>> hw/cpv_responder.sv
`timescale 1ns/10ps
// Notes on behaviour
// [R01] starts in idle after power-up and after hard or cable reset; idle is normal.
// [R02] discover identity request in idle moves to identity fetch, asks manager.
// [R03] identity answer sends identity ack; back to idle once sent.
// [R04] discover svids request in idle moves to svid fetch, asks manager.
// [R05] svid answer sends svid ack; back to idle once sent.
// [R06] discover modes request in idle moves to modes fetch, asks manager.
// [R07] modes answer sends modes ack; back to idle once sent.
// [R08] enter mode request in idle asks manager to judge and enter mode.
// [R09] manager reports mode entered: send enter ack, back to idle once sent.
// [R10] manager refuses: send enter nak as directed, back to idle once sent.
// [R11] exit mode request in idle enters leave state, asks manager to leave.
// [R12] mode left: send exit ack, back to idle once sent.
// [R13] soft reset message from any state but full restart enters soft restart; during full restart it is held until idle.
// [R14] soft restart resets protocol layer, then sends accept, then idle.
// [R15] transmit error during soft restart moves to full restart.
// [R16] hard or cable reset signaling from any state enters full restart.
// [R17] full restart resets whole plug like power cycle, idle when complete.
// [R18] hard or cable reset beats a soft reset arriving in the same cycle.
module cpv_responder
    import cpv_pkg::*;
#(
    parameter int PLUG_RST_CYCLES = 16,
    parameter int PRL_RST_CYCLES  = 4
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        clk_en_i,
    input  wire cpv_req_t    req_i,
    output logic             req_ready_o,
    input  wire logic        soft_rst_msg_i,
    input  wire logic        hard_rst_sig_i,
    input  wire logic        cable_rst_sig_i,
    output cpv_pm_req_t      pm_req_o,
    input  wire cpv_pm_ans_t pm_ans_i,
    output cpv_tx_t          tx_o,
    input  wire logic        tx_sent_i,
    input  wire logic        tx_err_i,
    output logic             prl_rst_o,
    output logic             plug_rst_o,
    output logic [4:0]       state_o
);

    typedef enum logic [4:0] {
        plug_idle_state,
        plug_fetch_identity_state,
        plug_reply_identity_state,
        plug_fetch_svid_state,
        plug_reply_svid_state,
        plug_fetch_modes_state,
        plug_reply_modes_state,
        plug_judge_entry_state,
        plug_entry_accept_state,
        plug_entry_refuse_state,
        plug_leave_mode_state,
        plug_leave_accept_state,
        plug_soft_restart_state,
        plug_soft_accept_state,
        plug_full_restart_state
    } cpv_state_t;

    cpv_state_t           state_r;
    cpv_state_t           state_nxt;
    logic [CPV_OBJ_W-1:0] obj_r;
    logic [CPV_OBJ_W-1:0] obj_nxt;
    logic                 tx_issued_r;
    logic                 tx_issued_nxt;
    cpv_pm_req_t          pm_req_r;
    cpv_pm_req_t          pm_req_nxt;
    cpv_tx_t              tx_r;
    cpv_tx_t              tx_nxt;

    logic hard_evt;
    logic esc_err;
    logic soft_pend;
    logic soft_take;
    logic idle_take;
    logic fetching;
    logic pm_ok;
    logic pm_nak;
    logic plug_busy;
    logic plug_done;
    logic prl_busy;
    logic prl_done;
    logic enter_full;
    logic enter_soft;
    logic reply_state;

    assign hard_evt = hard_rst_sig_i | cable_rst_sig_i;                            // [R16]
    assign esc_err    = tx_err_i & ((state_r == plug_soft_restart_state) |
                                    (state_r == plug_soft_accept_state));          // [R15]
    assign enter_full = (hard_evt | esc_err) & (state_r != plug_full_restart_state); // [R16]
    assign soft_take  = soft_pend & ~hard_evt & (state_r != plug_full_restart_state); // [R18]
    assign enter_soft = soft_take & (state_r != plug_soft_restart_state);          // [R13]
    assign idle_take  = (state_r == plug_idle_state) & req_i.valid & ~hard_evt & ~soft_pend;
    assign req_ready_o = (state_r == plug_idle_state) & ~hard_evt & ~soft_pend;
    assign fetching   = (state_r == plug_fetch_identity_state) |
                        (state_r == plug_fetch_svid_state) |
                        (state_r == plug_fetch_modes_state) |
                        (state_r == plug_judge_entry_state) |
                        (state_r == plug_leave_mode_state);
    assign pm_ok  = fetching & pm_ans_i.valid & ~pm_ans_i.nak;
    assign pm_nak = fetching & pm_ans_i.valid & pm_ans_i.nak;
    assign reply_state = (state_r == plug_reply_identity_state) |
                         (state_r == plug_reply_svid_state) |
                         (state_r == plug_reply_modes_state) |
                         (state_r == plug_entry_accept_state) |
                         (state_r == plug_entry_refuse_state) |
                         (state_r == plug_leave_accept_state) |
                         (state_r == plug_soft_accept_state);

    // soft reset message kept until the machine takes it or a hard or cable reset drops it
    cpv_event_latch u_soft_latch (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .en_i    (clk_en_i),
        .set_i   (soft_rst_msg_i & ~hard_evt),                                     // [R18]
        .clr_i   (soft_take | hard_evt),
        .flag_o  (soft_pend)
    );

    cpv_reset_timer #(.CYCLES(PLUG_RST_CYCLES)) u_plug_timer (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .en_i    (clk_en_i),
        .start_i (enter_full),
        .busy_o  (plug_busy),
        .done_o  (plug_done)
    );

    cpv_reset_timer #(.CYCLES(PRL_RST_CYCLES)) u_prl_timer (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .en_i    (clk_en_i),
        .start_i (enter_soft),
        .busy_o  (prl_busy),
        .done_o  (prl_done)
    );

    assign prl_rst_o  = prl_busy & (state_r == plug_soft_restart_state);           // [R14]
    assign plug_rst_o = plug_busy;                                                 // [R17]

    always_comb begin
        state_nxt     = state_r;
        obj_nxt       = obj_r;
        tx_issued_nxt = tx_issued_r;
        pm_req_nxt    = pm_req_r;
        tx_nxt        = tx_r;
        pm_req_nxt.valid = 1'b0;
        tx_nxt.valid     = 1'b0;
        if (enter_full) begin
            state_nxt     = plug_full_restart_state;                               // [R16]
            tx_issued_nxt = 1'b0;
        end else if (enter_soft) begin
            state_nxt     = plug_soft_restart_state;                               // [R13]
            tx_issued_nxt = 1'b0;
        end else begin
            case (state_r)
                plug_idle_state: begin
                    tx_issued_nxt = 1'b0;
                    if (idle_take) begin
                        obj_nxt = req_i.obj;
                        pm_req_nxt.valid = 1'b1;
                        pm_req_nxt.obj   = req_i.obj;
                        case (req_i.cmd)
                            CPV_CMD_DISC_IDENT: begin
                                state_nxt = plug_fetch_identity_state;             // [R02]
                                pm_req_nxt.ask = CPV_ASK_IDENT;
                            end
                            CPV_CMD_DISC_SVID: begin
                                state_nxt = plug_fetch_svid_state;                 // [R04]
                                pm_req_nxt.ask = CPV_ASK_SVID;
                            end
                            CPV_CMD_DISC_MODES: begin
                                state_nxt = plug_fetch_modes_state;                // [R06]
                                pm_req_nxt.ask = CPV_ASK_MODES;
                            end
                            CPV_CMD_ENTER_MODE: begin
                                state_nxt = plug_judge_entry_state;                // [R08]
                                pm_req_nxt.ask = CPV_ASK_ENTER;
                            end
                            CPV_CMD_EXIT_MODE: begin
                                state_nxt = plug_leave_mode_state;                 // [R11]
                                pm_req_nxt.ask = CPV_ASK_EXIT;
                            end
                            default: begin
                                pm_req_nxt.valid = 1'b0;
                            end
                        endcase
                    end
                end
                plug_fetch_identity_state: begin
                    if (pm_ans_i.valid) begin
                        state_nxt = plug_reply_identity_state;                     // [R03]
                        obj_nxt   = pm_ans_i.obj;
                    end
                end
                plug_fetch_svid_state: begin
                    if (pm_ans_i.valid) begin
                        state_nxt = plug_reply_svid_state;                         // [R05]
                        obj_nxt   = pm_ans_i.obj;
                    end
                end
                plug_fetch_modes_state: begin
                    if (pm_ans_i.valid) begin
                        state_nxt = plug_reply_modes_state;                        // [R07]
                        obj_nxt   = pm_ans_i.obj;
                    end
                end
                plug_judge_entry_state: begin
                    if (pm_ok) begin
                        state_nxt = plug_entry_accept_state;                       // [R09]
                        obj_nxt   = pm_ans_i.obj;
                    end else if (pm_nak) begin
                        state_nxt = plug_entry_refuse_state;                       // [R10]
                        obj_nxt   = pm_ans_i.obj;
                    end
                end
                plug_leave_mode_state: begin
                    if (pm_ans_i.valid) begin
                        state_nxt = plug_leave_accept_state;                       // [R12]
                        obj_nxt   = pm_ans_i.obj;
                    end
                end
                plug_soft_restart_state: begin
                    if (prl_done) begin
                        state_nxt = plug_soft_accept_state;                        // [R14]
                        obj_nxt   = CPV_OBJ_RST;
                    end
                end
                plug_full_restart_state: begin
                    obj_nxt = CPV_OBJ_RST;
                    if (plug_done) begin
                        state_nxt = plug_idle_state;                               // [R17]
                    end
                end
                default: begin
                    // reply states: issue once, wait for sent
                    if (!tx_issued_r) begin
                        tx_issued_nxt = 1'b1;
                        tx_nxt.valid  = 1'b1;
                        tx_nxt.obj    = obj_r;
                        case (state_r)
                            plug_reply_identity_state: tx_nxt.rsp = CPV_RSP_IDENT_ACK; // [R03]
                            plug_reply_svid_state:     tx_nxt.rsp = CPV_RSP_SVID_ACK;  // [R05]
                            plug_reply_modes_state:    tx_nxt.rsp = CPV_RSP_MODES_ACK; // [R07]
                            plug_entry_accept_state:   tx_nxt.rsp = CPV_RSP_ENTER_ACK; // [R09]
                            plug_entry_refuse_state:   tx_nxt.rsp = CPV_RSP_ENTER_NAK; // [R10]
                            plug_leave_accept_state:   tx_nxt.rsp = CPV_RSP_EXIT_ACK;  // [R12]
                            default:                   tx_nxt.rsp = CPV_RSP_ACCEPT;    // [R14]
                        endcase
                    end else if (reply_state && tx_sent_i) begin
                        state_nxt     = plug_idle_state;
                        tx_issued_nxt = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r     <= plug_idle_state;                                        // [R01]
            obj_r       <= CPV_OBJ_RST;
            tx_issued_r <= 1'b0;
            pm_req_r    <= '0;
            tx_r        <= '0;
        end else if (clk_en_i) begin
            state_r     <= state_nxt;
            obj_r       <= obj_nxt;
            tx_issued_r <= tx_issued_nxt;
            pm_req_r    <= pm_req_nxt;
            tx_r        <= tx_nxt;
        end
    end

    assign pm_req_o = pm_req_r;
    assign tx_o     = tx_r;
    assign state_o  = state_r;

endmodule : cpv_responder

// >>> testbench/cpv_responder_monitor.sv
`timescale 1ns/10ps
module cpv_responder_monitor
    import cpv_pkg::*;
#(
    parameter int PLUG_RST_CYCLES = 16,
    parameter int PRL_RST_CYCLES  = 4
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        clk_en_i,
    input  wire cpv_req_t    req_i,
    input  wire logic        req_ready_o,
    input  wire logic        soft_rst_msg_i,
    input  wire logic        hard_rst_sig_i,
    input  wire logic        cable_rst_sig_i,
    input  wire cpv_pm_req_t pm_req_o,
    input  wire cpv_pm_ans_t pm_ans_i,
    input  wire cpv_tx_t     tx_o,
    input  wire logic        tx_sent_i,
    input  wire logic        tx_err_i,
    input  wire logic        prl_rst_o,
    input  wire logic        plug_rst_o,
    input  wire logic [4:0]  state_o
);
    int   plug_cnt_r;
    int   prl_cnt_r;
    logic sent_ok_r;
    wire  quiet = clk_en_i && !hard_rst_sig_i && !cable_rst_sig_i && !soft_rst_msg_i;
    wire  take  = clk_en_i && req_i.valid && req_ready_o;
    wire  ans   = pm_ans_i.valid && quiet;
    wire  hit   = clk_en_i && (hard_rst_sig_i || cable_rst_sig_i);
    wire  reply = state_o inside {5'd2, 5'd4, 5'd6, 5'd8, 5'd9, 5'd11, 5'd13};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            plug_cnt_r <= 0;
            prl_cnt_r  <= 0;
            sent_ok_r  <= 1'b0;
        end else if (clk_en_i) begin
            plug_cnt_r <= plug_rst_o ? plug_cnt_r + 1 : 0;
            prl_cnt_r  <= prl_rst_o ? prl_cnt_r + 1 : 0;
            sent_ok_r  <= tx_o.valid || (sent_ok_r && reply);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_ident_take;
        take && req_i.cmd == CPV_CMD_DISC_IDENT |=> state_o == 5'd1 && pm_req_o.valid
            && pm_req_o.ask == CPV_ASK_IDENT && pm_req_o.obj == $past(req_i.obj);
    endproperty
    a_ident_take: assert property (p_ident_take) else $error("identity query missing");
    property p_enter_take;
        take && req_i.cmd == CPV_CMD_ENTER_MODE |=> state_o == 5'd7 && pm_req_o.valid
            && pm_req_o.ask == CPV_ASK_ENTER;
    endproperty
    a_enter_take: assert property (p_enter_take) else $error("entry query missing");
    property p_exit_take;
        take && req_i.cmd == CPV_CMD_EXIT_MODE |=> state_o == 5'd10 && pm_req_o.ask == CPV_ASK_EXIT;
    endproperty
    a_exit_take: assert property (p_exit_take) else $error("exit query missing");
    property p_ident_ans;
        state_o == 5'd1 && ans |=> state_o == 5'd2 ##1 tx_o.valid
            && tx_o.rsp == CPV_RSP_IDENT_ACK && tx_o.obj == $past(pm_ans_i.obj, 2);
    endproperty
    a_ident_ans: assert property (p_ident_ans) else $error("identity reply wrong");
    property p_enter_ack;
        state_o == 5'd7 && ans && !pm_ans_i.nak |=> state_o == 5'd8 ##1 tx_o.valid
            && tx_o.rsp == CPV_RSP_ENTER_ACK;
    endproperty
    a_enter_ack: assert property (p_enter_ack) else $error("entry ack wrong");
    property p_enter_nak;
        state_o == 5'd7 && ans && pm_ans_i.nak |=> state_o == 5'd9 ##1 tx_o.valid
            && tx_o.rsp == CPV_RSP_ENTER_NAK;
    endproperty
    a_enter_nak: assert property (p_enter_nak) else $error("entry nak wrong");
    property p_sent_idle;
        reply && sent_ok_r && tx_sent_i && !tx_err_i && quiet |=> state_o == 5'd0;
    endproperty
    a_sent_idle: assert property (p_sent_idle) else $error("no idle after sent");
    property p_soft;
        soft_rst_msg_i && hit == 1'b0 && clk_en_i && !(state_o inside {5'd12, 5'd13, 5'd14})
            |-> ##[1:2] state_o == 5'd12;
    endproperty
    a_soft: assert property (p_soft) else $error("soft restart not entered");
    property p_err;
        state_o inside {5'd12, 5'd13} && tx_err_i && clk_en_i && !hit |=> state_o == 5'd14;
    endproperty
    a_err: assert property (p_err) else $error("transmit error ignored");
    property p_hard;
        hit && state_o != 5'd14 |=> state_o == 5'd14 && plug_rst_o && !prl_rst_o;
    endproperty
    a_hard: assert property (p_hard) else $error("full restart not entered");
    property p_plug_len;
        $fell(plug_rst_o) |-> plug_cnt_r == PLUG_RST_CYCLES && state_o == 5'd0;
    endproperty
    a_plug_len: assert property (p_plug_len) else $error("plug reset length wrong");
    property p_prl_len;
        $fell(prl_rst_o) && state_o == 5'd13 |-> prl_cnt_r == PRL_RST_CYCLES ##1 tx_o.valid
            && tx_o.rsp == CPV_RSP_ACCEPT && tx_o.obj == CPV_OBJ_RST;
    endproperty
    a_prl_len: assert property (p_prl_len) else $error("accept sequence wrong");
endmodule : cpv_responder_monitor

bind cpv_responder cpv_responder_monitor #(
    .PLUG_RST_CYCLES(PLUG_RST_CYCLES),
    .PRL_RST_CYCLES (PRL_RST_CYCLES)
) u_mon (.*);

// >>> testbench/cpv_pm_model.sv
`timescale 1ns/10ps
module cpv_pm_model
    import cpv_pkg::*;
#(
    parameter logic [CPV_OBJ_W-1:0] ANS_KEY = 32'h5A3C_96E1
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [2:0]  dly_i,
    input  wire logic        nak_i,
    input  wire logic        err_i,
    input  wire cpv_pm_req_t pm_req_i,
    input  wire cpv_tx_t     tx_i,
    output cpv_pm_ans_t      pm_ans_o,
    output logic             tx_sent_o,
    output logic             tx_err_o
);
    int                   ans_cnt;
    int                   tx_cnt;
    logic                 ans_nak;
    logic [CPV_OBJ_W-1:0] ans_obj;
    logic                 tx_bad;

    always @(negedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ans_cnt = -1;
            tx_cnt = -1;
            pm_ans_o <= '0;
            tx_sent_o <= 1'b0;
            tx_err_o <= 1'b0;
        end else begin
            if (ans_cnt == 0) pm_ans_o <= {1'b1, ans_nak, ans_obj};
            else pm_ans_o <= {1'b0, ~pm_ans_o.nak, ~pm_ans_o.obj};
            tx_sent_o <= (tx_cnt == 0) && !tx_bad;
            tx_err_o <= (tx_cnt == 0) && tx_bad;
            if (ans_cnt >= 0) ans_cnt--;
            if (tx_cnt >= 0) tx_cnt--;
            if (pm_req_i.valid) begin
                ans_cnt = dly_i;
                ans_nak = nak_i && pm_req_i.ask == CPV_ASK_ENTER;
                ans_obj = pm_req_i.obj ^ ANS_KEY;
            end
            if (tx_i.valid) begin
                tx_cnt = dly_i;
                tx_bad = err_i && tx_i.rsp == CPV_RSP_ACCEPT;
            end
        end
    end
endmodule : cpv_pm_model

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import cpv_pkg::*;
;
    localparam int                   PLUG_N = 6;
    localparam int                   PRL_N  = 3;
    localparam logic [CPV_OBJ_W-1:0] KEY    = 32'h3C69_A5F0;
    logic clk, rst_n, clk_en, req_ready, soft_rst, hard_rst, cable_rst;
    logic tx_sent, tx_err, prl_rst, plug_rst, nak, err;
    logic [2:0]  dly;
    logic [4:0]  state;
    cpv_req_t    req;
    cpv_pm_req_t pm_req;
    cpv_pm_ans_t pm_ans;
    cpv_tx_t     tx;
    int err_total = 0;
    int checks = 0;
    int seed = 81856;
    int cyc = 0;
    int r;
    cpv_ask_t q_ask[$];
    cpv_rsp_t q_rsp[$];
    logic [CPV_OBJ_W-1:0] q_aobj[$];
    logic [CPV_OBJ_W-1:0] q_obj[$];

    cpv_responder #(.PLUG_RST_CYCLES(PLUG_N), .PRL_RST_CYCLES(PRL_N)) uut (
        .clk_i(clk), .rst_n_i(rst_n), .clk_en_i(clk_en), .req_i(req), .req_ready_o(req_ready),
        .soft_rst_msg_i(soft_rst), .hard_rst_sig_i(hard_rst), .cable_rst_sig_i(cable_rst),
        .pm_req_o(pm_req), .pm_ans_i(pm_ans), .tx_o(tx), .tx_sent_i(tx_sent),
        .tx_err_i(tx_err), .prl_rst_o(prl_rst), .plug_rst_o(plug_rst), .state_o(state));
    cpv_pm_model #(.ANS_KEY(KEY)) u_pm (
        .clk_i(clk), .rst_n_i(rst_n), .dly_i(dly), .nak_i(nak), .err_i(err), .pm_req_i(pm_req),
        .tx_i(tx), .pm_ans_o(pm_ans), .tx_sent_o(tx_sent), .tx_err_o(tx_err));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    function automatic cpv_rsp_t rsp_of(cpv_cmd_t c, logic n);
        case (c)
            CPV_CMD_DISC_IDENT: return CPV_RSP_IDENT_ACK;
            CPV_CMD_DISC_SVID:  return CPV_RSP_SVID_ACK;
            CPV_CMD_DISC_MODES: return CPV_RSP_MODES_ACK;
            CPV_CMD_ENTER_MODE: return n ? CPV_RSP_ENTER_NAK : CPV_RSP_ENTER_ACK;
            default:            return CPV_RSP_EXIT_ACK;
        endcase
    endfunction : rsp_of

    always @(negedge clk) begin
        if (pm_req.valid === 1'b1) begin
            check(q_ask.size() > 0, "unexpected query");
            if (q_ask.size() > 0) begin
                check(pm_req.ask === q_ask.pop_front(), "query kind");
                check(pm_req.obj === q_aobj.pop_front(), "query object");
            end
        end
        if (tx.valid === 1'b1) begin
            check(q_rsp.size() > 0, "unexpected response");
            if (q_rsp.size() > 0) begin
                check(tx.rsp === q_rsp.pop_front(), "response kind");
                check(tx.obj === q_obj.pop_front(), "response object");
            end
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            err_total++;
            $display("[FAIL] %0t run took too long", $time);
            wrap_up();
        end
    end

    task automatic wait_idle(output int n_plug, output int n_prl);
        n_plug = 0;
        n_prl = 0;
        for (int i = 0; i < 300; i++) begin
            @(negedge clk);
            req.valid = (i == 3);
            {cable_rst, hard_rst, soft_rst} = 3'b000;
            n_plug += (plug_rst === 1'b1);
            n_prl += (prl_rst === 1'b1);
            if (i >= 4 && state === 5'd0) break;
        end
        check(state === 5'd0, "no return to idle");
    endtask : wait_idle

    // f bits: soft, hard, cable pulse one cycle after the request; e makes the accept fail
    task automatic run(input cpv_cmd_t c, input logic n, input logic [2:0] f, input logic e);
        logic [CPV_OBJ_W-1:0] o;
        int np;
        int nr;
        @(negedge clk);
        o = $random(seed);
        nak = n;
        err = e;
        dly = (f != 3'd0) ? 3'd6 : 3'($random(seed));
        req = '{1'b1, c, o};
        if (c != CPV_CMD_NONE) begin
            q_ask.push_back(cpv_ask_t'(c - 1));
            q_aobj.push_back(o);
        end
        if (c != CPV_CMD_NONE && f == 3'd0) begin
            q_rsp.push_back(rsp_of(c, n));
            q_obj.push_back(o ^ KEY);
        end
        if (f == 3'b001) begin
            q_rsp.push_back(CPV_RSP_ACCEPT);
            q_obj.push_back(CPV_OBJ_RST);
        end
        if (f != 3'd0) begin
            @(negedge clk);
            req.valid = 1'b0;
            {cable_rst, hard_rst, soft_rst} = f;
        end
        wait_idle(np, nr);
        check(np == ((f[2:1] != 2'd0 || e) ? PLUG_N : 0), "plug reset length");
        check(nr == ((f == 3'b001) ? PRL_N : 0), "protocol reset length");
    endtask : run

    initial begin
        {clk_en, rst_n, soft_rst, hard_rst, cable_rst, nak, err} = 7'b1000000;
        req = '0;
        dly = 3'd0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        check(state === 5'd0 && req_ready === 1'b1, "not idle after reset");
        for (int k = 1; k <= 5; k++) run(cpv_cmd_t'(k), 1'b0, 3'd0, 1'b0);
        run(CPV_CMD_ENTER_MODE, 1'b1, 3'd0, 1'b0);
        for (int k = 0; k < 16; k++) begin
            r = $unsigned($random(seed)) % 5;
            run(cpv_cmd_t'(1 + r), 1'($random(seed)), 3'd0, 1'b0);
        end
        run(CPV_CMD_NONE, 1'b0, 3'b001, 1'b0);
        run(CPV_CMD_NONE, 1'b0, 3'b001, 1'b1);
        run(CPV_CMD_NONE, 1'b0, 3'b010, 1'b0);
        run(CPV_CMD_DISC_SVID, 1'b0, 3'b001, 1'b0);
        run(CPV_CMD_DISC_MODES, 1'b0, 3'b010, 1'b0);
        run(CPV_CMD_EXIT_MODE, 1'b0, 3'b100, 1'b0);
        run(CPV_CMD_NONE, 1'b0, 3'b011, 1'b0);
        @(negedge clk);
        clk_en = 1'b0;
        req = '{1'b1, CPV_CMD_DISC_IDENT, 32'h0000_0001};
        repeat (3) @(negedge clk);
        check(state === 5'd0, "frozen engine moved");
        req.valid = 1'b0;
        clk_en = 1'b1;
        run(CPV_CMD_DISC_IDENT, 1'b0, 3'd0, 1'b0);
        check(q_rsp.size() == 0 && q_ask.size() == 0, "responses missing");
        wrap_up();
    end
endmodule : tb_top
